// file: rtl/mcu_interrupt_sequencer.sv
// interrupt recognition, priority and vectoring for the processor core
`timescale 1ns/1ps

// Contract
// RQ1: pin interrupt taken only if mask clear, enable set and pin matches option.
// RQ2: pin service pushes state, sets mask, fetches vector 1ffa/1ffb.
// RQ3: bits 6 and 5 pick pin trigger: fall+low, fall, rise, both edges.
// RQ4: reset clears both sense bits: falling edge plus low level.
// RQ5: bit 4 enables pin interrupt; reset sets it.
// RQ6: sense and enable bits writable only while mask is set.
// RQ7: changing the pin option clears a pending pin request.
// RQ8: edge seen while disabled is latched until enable is set.
// RQ9: latch cleared at service start; low level is never latched.
// RQ10: timer request when any enabled flag in status bits 7..3 is set.
// RQ11: capture vector 1ff8, compare 1ff6, overflow 1ff4.
// RQ12: three timer enables gate capture pair, compare pair, overflow.
// RQ13: serial request when any enabled serial status flag is set.
// RQ14: four serial enables gate empty, complete, overrun/full, idle.
// RQ15: all serial causes share vector 1ff2/1ff3; software finds cause.
// RQ16: serial flag clears after status access then serial data access.
// RQ17: reset fetches start vector 1ffe/1fff and sets mask.
// RQ18: stop halts oscillator and core; only pin interrupt or reset wakes.
// RQ19: wait stops core clocks, timer runs; any interrupt wakes, normal vectors.
// RQ20: priority reset, swi, pin, capture, compare, overflow, serial.
// RQ21: requests checked only when the current instruction completes.
// RQ22: level option keeps requesting while pin stays low.
module mcu_interrupt_sequencer (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [7:0] reg_rdata_o,
  // external interrupt pin, active low
  input wire logic irq_pin_n_i,
  // peripheral flags
  input wire logic [4:0] timer_flags_i,
  input wire logic [4:0] serial_flags_i,
  output logic [4:0] serial_flag_clear_o,
  // processor core
  input wire logic instr_done_i,
  input wire logic swi_exec_i,
  input wire logic stop_exec_i,
  input wire logic wait_exec_i,
  input wire logic mask_set_i,
  input wire logic mask_clr_i,
  output logic mask_o,
  output logic service_start_o,
  output logic stack_push_o,
  output logic [15:0] vector_addr_o,
  // clock control
  output logic osc_enable_o,
  output logic cpu_clk_enable_o,
  output logic timer_clk_enable_o
);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    irq_seq_pkg::state_type state;
    logic mask;
    logic rise_sel;
    logic fall_sel;
    logic pin_en;
    logic pin_latch;
    logic por_flag;
    logic [3:0] misc_low;
    logic [7:0] timer_ctl;
    logic [7:0] serial_ctl;
    logic [4:0] serial_arm;
    logic [4:0] serial_clr;
    logic [7:0] rdata;
    logic take;
    logic push;
    logic [15:0] vector;
    logic osc_en;
    logic cpu_clk_en;
    logic timer_clk_en;
  } seq_type;

  localparam seq_type seq_reset = '{
    state: irq_seq_pkg::st_boot,
    mask: 1'b1,
    rise_sel: 1'b0,
    fall_sel: 1'b0,
    pin_en: 1'b1,
    pin_latch: 1'b0,
    por_flag: 1'b1,
    misc_low: irq_seq_pkg::misc_low_reset,
    timer_ctl: irq_seq_pkg::control_reset,
    serial_ctl: irq_seq_pkg::control_reset,
    serial_arm: 5'h00,
    serial_clr: 5'h00,
    rdata: 8'h00,
    take: 1'b0,
    push: 1'b0,
    vector: irq_seq_pkg::reset_vector,
    osc_en: 1'b1,
    cpu_clk_en: 1'b1,
    timer_clk_en: 1'b1
  };

  seq_type q;
  seq_type d;

  // ************************************************************
  // pin conditioning
  // ************************************************************
  logic pin_level;
  logic pin_rise;
  logic pin_fall;

  pin_sync u_pin_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(irq_pin_n_i),
    .level_o(pin_level),
    .rise_o(pin_rise),
    .fall_o(pin_fall)
  );

  // ************************************************************
  // request terms
  // ************************************************************
  logic level_mode;
  logic edge_hit;
  logic pin_req;
  logic cap_req;
  logic cmp_req;
  logic ovf_req;
  logic ser_req;
  logic any_req;
  logic [15:0] hw_vector;
  logic [7:0] misc_read;

  always_comb begin
    level_mode = ~q.rise_sel & ~q.fall_sel;
    // falling edge in options 00, 01, 11; rising edge in 10, 11
    edge_hit = (pin_fall & ~(q.rise_sel & ~q.fall_sel)) | (pin_rise & q.rise_sel); // RQ3
    // level request is live, never stored
    pin_req = q.pin_en & (q.pin_latch | (level_mode & ~pin_level)); // RQ1 RQ22
    cap_req = (timer_flags_i[irq_seq_pkg::capture_one_flag]
              | timer_flags_i[irq_seq_pkg::capture_two_flag])
              & q.timer_ctl[irq_seq_pkg::capture_irq_en_bit]; // RQ10 RQ12
    cmp_req = (timer_flags_i[irq_seq_pkg::compare_one_flag]
              | timer_flags_i[irq_seq_pkg::compare_two_flag])
              & q.timer_ctl[irq_seq_pkg::compare_irq_en_bit]; // RQ10 RQ12
    ovf_req = timer_flags_i[irq_seq_pkg::timer_overflow_flag]
              & q.timer_ctl[irq_seq_pkg::overflow_irq_en_bit]; // RQ10 RQ12
    ser_req = (serial_flags_i[irq_seq_pkg::tx_empty_flag]
              & q.serial_ctl[irq_seq_pkg::tx_empty_irq_en_bit])
              | (serial_flags_i[irq_seq_pkg::transmit_complete_flag]
              & q.serial_ctl[irq_seq_pkg::tx_done_irq_en_bit])
              | ((serial_flags_i[irq_seq_pkg::overrun_flag]
              | serial_flags_i[irq_seq_pkg::rx_full_flag])
              & q.serial_ctl[irq_seq_pkg::receive_irq_en_bit])
              | (serial_flags_i[irq_seq_pkg::idle_line_flag]
              & q.serial_ctl[irq_seq_pkg::quiet_line_irq_en_bit]); // RQ13 RQ14
    any_req = pin_req | cap_req | cmp_req | ovf_req | ser_req;
    // fixed priority among maskable sources
    if (pin_req) begin // RQ20
      hw_vector = irq_seq_pkg::pin_vector; // RQ2
    end else if (cap_req) begin
      hw_vector = irq_seq_pkg::capture_vector; // RQ11
    end else if (cmp_req) begin
      hw_vector = irq_seq_pkg::compare_vector; // RQ11
    end else if (ovf_req) begin
      hw_vector = irq_seq_pkg::overflow_vector; // RQ11
    end else begin
      hw_vector = irq_seq_pkg::serial_vector; // RQ15
    end
    misc_read = {q.por_flag, q.rise_sel, q.fall_sel, q.pin_en, q.misc_low};
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    d = q;
    d.take = 1'b0;
    d.push = 1'b0;
    d.serial_clr = 5'h00;
    d.rdata = 8'h00;

    // core-driven mask changes (sei, cli, rti restore)
    if (mask_clr_i) begin
      d.mask = 1'b0;
    end
    if (mask_set_i) begin
      d.mask = 1'b1;
    end

    // register reads, data stands in the following cycle
    if (reg_re_i) begin
      case (reg_addr_i)
        irq_seq_pkg::misc_control_addr: d.rdata = misc_read;
        irq_seq_pkg::serial_control_two_addr: d.rdata = q.serial_ctl;
        irq_seq_pkg::serial_status_addr: d.rdata = {serial_flags_i, 3'b000};
        irq_seq_pkg::timer_control_addr: d.rdata = q.timer_ctl;
        irq_seq_pkg::timer_status_addr: d.rdata = {timer_flags_i, 3'b000};
        default: d.rdata = 8'h00;
      endcase
    end

    // serial flag clear: status access arms, data access fires
    if ((reg_re_i || reg_we_i) && reg_addr_i == irq_seq_pkg::serial_status_addr) begin
      d.serial_arm = serial_flags_i; // RQ16
    end
    if ((reg_re_i || reg_we_i) && reg_addr_i == irq_seq_pkg::serial_data_addr) begin
      d.serial_clr = q.serial_arm; // RQ16
      d.serial_arm = 5'h00;
    end

    // register writes
    if (reg_we_i) begin
      case (reg_addr_i)
        irq_seq_pkg::misc_control_addr: begin
          d.misc_low = reg_wdata_i[3:0];
          if (!reg_wdata_i[irq_seq_pkg::por_flag_bit]) begin
            d.por_flag = 1'b0;
          end
          // option bits locked while interrupts are unmasked
          if (q.mask) begin // RQ6
            d.rise_sel = reg_wdata_i[irq_seq_pkg::rise_sense_select_bit];
            d.fall_sel = reg_wdata_i[irq_seq_pkg::fall_sense_select_bit];
            d.pin_en = reg_wdata_i[irq_seq_pkg::pin_irq_enable_bit]; // RQ5
            if (reg_wdata_i[irq_seq_pkg::rise_sense_select_bit] != q.rise_sel
                || reg_wdata_i[irq_seq_pkg::fall_sense_select_bit] != q.fall_sel) begin
              d.pin_latch = 1'b0; // RQ7
            end
          end
        end
        irq_seq_pkg::serial_control_two_addr: d.serial_ctl = reg_wdata_i;
        irq_seq_pkg::timer_control_addr: d.timer_ctl = reg_wdata_i;
        default: d.rdata = d.rdata;
      endcase
    end

    // sequencing
    case (q.state)
      irq_seq_pkg::st_boot: begin
        d.take = 1'b1;
        d.vector = irq_seq_pkg::reset_vector; // RQ17
        d.mask = 1'b1; // RQ17
        d.state = irq_seq_pkg::st_run;
      end
      irq_seq_pkg::st_run: begin
        if (stop_exec_i) begin
          d.state = irq_seq_pkg::st_stop;
          d.mask = 1'b0;
          d.osc_en = 1'b0; // RQ18
          d.cpu_clk_en = 1'b0;
          d.timer_clk_en = 1'b0;
        end else if (wait_exec_i) begin
          d.state = irq_seq_pkg::st_wait;
          d.mask = 1'b0;
          d.cpu_clk_en = 1'b0; // RQ19
        end else if (instr_done_i) begin // RQ21
          if (swi_exec_i) begin
            // swi is not maskable
            d.take = 1'b1;
            d.push = 1'b1;
            d.mask = 1'b1;
            d.vector = irq_seq_pkg::swi_vector; // RQ20
          end else if (!q.mask && any_req) begin // RQ1
            d.take = 1'b1;
            d.push = 1'b1; // RQ2
            d.mask = 1'b1; // RQ2
            d.vector = hw_vector;
            if (pin_req) begin
              d.pin_latch = 1'b0; // RQ9
            end
          end
        end
      end
      irq_seq_pkg::st_stop: begin
        // oscillator is off; only the pin path can wake
        if (pin_req && !q.mask) begin // RQ18
          d.state = irq_seq_pkg::st_run;
          d.osc_en = 1'b1;
          d.cpu_clk_en = 1'b1;
          d.timer_clk_en = 1'b1;
          d.take = 1'b1;
          d.push = 1'b1;
          d.mask = 1'b1;
          d.vector = irq_seq_pkg::pin_vector;
          d.pin_latch = 1'b0; // RQ9
        end
      end
      irq_seq_pkg::st_wait: begin
        if (any_req && !q.mask) begin // RQ19
          d.state = irq_seq_pkg::st_run;
          d.cpu_clk_en = 1'b1;
          d.take = 1'b1;
          d.push = 1'b1;
          d.mask = 1'b1;
          d.vector = hw_vector;
          if (pin_req) begin
            d.pin_latch = 1'b0; // RQ9
          end
        end
      end
      default: d.state = irq_seq_pkg::st_boot;
    endcase

    // edge latching comes last so a fresh edge beats any clear
    if (edge_hit) begin
      d.pin_latch = 1'b1; // RQ8 RQ9
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= seq_reset; // RQ4 RQ5 RQ17
    end else begin
      q <= d;
    end
  end

  assign reg_rdata_o = q.rdata;
  assign serial_flag_clear_o = q.serial_clr;
  assign mask_o = q.mask;
  assign service_start_o = q.take;
  assign stack_push_o = q.push;
  assign vector_addr_o = q.vector;
  assign osc_enable_o = q.osc_en;
  assign cpu_clk_enable_o = q.cpu_clk_en;
  assign timer_clk_enable_o = q.timer_clk_en;

endmodule

// file: rtl/irq_seq_pkg.sv
// constants, field layouts and state codes for the interrupt sequencer
package irq_seq_pkg;

  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [7:0] misc_control_addr = 8'h0c;
  localparam logic [7:0] serial_control_two_addr = 8'h0f;
  localparam logic [7:0] serial_status_addr = 8'h10;
  localparam logic [7:0] serial_data_addr = 8'h11;
  localparam logic [7:0] timer_control_addr = 8'h12;
  localparam logic [7:0] timer_status_addr = 8'h13;

  // ************************************************************
  // misc_control fields
  // ************************************************************
  localparam int por_flag_bit = 7;
  localparam int rise_sense_select_bit = 6;
  localparam int fall_sense_select_bit = 5;
  localparam int pin_irq_enable_bit = 4;
  localparam logic [3:0] misc_low_reset = 4'h0;

  // ************************************************************
  // timer and serial fields
  // ************************************************************
  localparam int capture_irq_en_bit = 7;
  localparam int compare_irq_en_bit = 6;
  localparam int overflow_irq_en_bit = 5;
  localparam int tx_empty_irq_en_bit = 7;
  localparam int tx_done_irq_en_bit = 6;
  localparam int receive_irq_en_bit = 5;
  localparam int quiet_line_irq_en_bit = 4;
  // flag vectors are five wide, held in status bits 7..3
  localparam int flag_shift = 3;
  localparam int capture_one_flag = 4;
  localparam int capture_two_flag = 3;
  localparam int compare_one_flag = 2;
  localparam int compare_two_flag = 1;
  localparam int timer_overflow_flag = 0;
  localparam int tx_empty_flag = 4;
  localparam int transmit_complete_flag = 3;
  localparam int overrun_flag = 2;
  localparam int rx_full_flag = 1;
  localparam int idle_line_flag = 0;
  localparam logic [7:0] control_reset = 8'h00;

  // ************************************************************
  // vectors
  // ************************************************************
  localparam logic [15:0] reset_vector = 16'h1ffe;
  localparam logic [15:0] swi_vector = 16'h1ffc;
  localparam logic [15:0] pin_vector = 16'h1ffa;
  localparam logic [15:0] capture_vector = 16'h1ff8;
  localparam logic [15:0] compare_vector = 16'h1ff6;
  localparam logic [15:0] overflow_vector = 16'h1ff4;
  localparam logic [15:0] serial_vector = 16'h1ff2;

  typedef enum logic [1:0] {
    st_boot = 2'b00,
    st_run = 2'b01,
    st_stop = 2'b10,
    st_wait = 2'b11
  } state_type;

endpackage

// file: rtl/pin_sync.sv
// three-stage pin synchroniser with edge pulses
`timescale 1ns/1ps

module pin_sync (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // pin
  input wire logic pin_i,
  // conditioned outputs
  output logic level_o,
  output logic rise_o,
  output logic fall_o
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
    logic rise;
    logic fall;
  } sync_type;

  // idle level high: the pin is active low
  localparam sync_type sync_reset = '{s1: 1'b1, s2: 1'b1, s3: 1'b1, level: 1'b1,
                                      rise: 1'b0, fall: 1'b0};

  sync_type q;
  sync_type d;

  always_comb begin
    d = q;
    d.s1 = pin_i;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.rise = 1'b0;
    d.fall = 1'b0;
    // a change counts once stages two and three agree
    if ((q.s2 == q.s3) && (q.s3 != q.level)) begin
      d.level = q.s3;
      d.rise = q.s3;
      d.fall = ~q.s3;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= sync_reset;
    end else begin
      q <= d;
    end
  end

  assign level_o = q.level;
  assign rise_o = q.rise;
  assign fall_o = q.fall;

endmodule

// file: verif/mcu_interrupt_sequencer_monitor.sv
// port assertions for the interrupt sequencer
`timescale 1ns/1ps

module mcu_interrupt_sequencer_monitor (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  input wire logic [7:0] reg_rdata_o,
  // core side
  input wire logic stop_exec_i,
  input wire logic wait_exec_i,
  input wire logic mask_o,
  input wire logic service_start_o,
  input wire logic stack_push_o,
  input wire logic [15:0] vector_addr_o,
  input wire logic [4:0] serial_flag_clear_o,
  // clock control
  input wire logic osc_enable_o,
  input wire logic cpu_clk_enable_o,
  input wire logic timer_clk_enable_o
);
  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_boot_vector: assert property ($fell(rst_i) |-> ##[0:1] (service_start_o && !stack_push_o
    && vector_addr_o == irq_seq_pkg::reset_vector)) else $error("boot fetch missing");
  a_boot_mask: assert property ($fell(rst_i) |-> mask_o)
    else $error("mask clear after reset");
  a_service_mask: assert property (service_start_o |-> mask_o)
    else $error("service left mask clear");
  a_pin_push: assert property (
    service_start_o && vector_addr_o == irq_seq_pkg::pin_vector |-> stack_push_o)
    else $error("pin service without stacking");
  a_masked_quiet: assert property (
    service_start_o && stack_push_o && vector_addr_o != irq_seq_pkg::swi_vector |-> !$past(mask_o))
    else $error("service taken while masked");
  a_read_quiet: assert property (reg_rdata_o != 8'h00 |-> $past(reg_re_i))
    else $error("read data outside read slot");
  a_stop_clocks: assert property (stop_exec_i && cpu_clk_enable_o |=>
    !osc_enable_o && !cpu_clk_enable_o && !timer_clk_enable_o) else $error("stop kept clocks");
  a_stop_wake: assert property ($rose(osc_enable_o) |->
    service_start_o && vector_addr_o == irq_seq_pkg::pin_vector) else $error("stop woke wrongly");
  a_wait_clocks: assert property (wait_exec_i && !stop_exec_i && cpu_clk_enable_o |=>
    !cpu_clk_enable_o && timer_clk_enable_o && osc_enable_o) else $error("wait clocks wrong");
  a_wait_wake: assert property (
    $rose(cpu_clk_enable_o) && $past(osc_enable_o) |-> service_start_o && stack_push_o)
    else $error("wait ended without service");
  a_clear_cause: assert property (serial_flag_clear_o != 5'h00 |->
    $past(reg_addr_i) == irq_seq_pkg::serial_data_addr && ($past(reg_we_i) || $past(reg_re_i)))
    else $error("flag clear without data access");
endmodule

bind mcu_interrupt_sequencer mcu_interrupt_sequencer_monitor u_monitor (
  .clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_we_i(reg_we_i),
  .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o), .stop_exec_i(stop_exec_i),
  .wait_exec_i(wait_exec_i), .mask_o(mask_o), .service_start_o(service_start_o),
  .stack_push_o(stack_push_o), .vector_addr_o(vector_addr_o),
  .serial_flag_clear_o(serial_flag_clear_o), .osc_enable_o(osc_enable_o),
  .cpu_clk_enable_o(cpu_clk_enable_o), .timer_clk_enable_o(timer_clk_enable_o)
);

// file: verif/core_stub.sv
// processor core stand-in retiring one instruction every fourth clock
`timescale 1ns/1ps

module core_stub (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // clock gate from the sequencer
  input wire logic cpu_clk_enable_i,
  // instruction boundary
  output logic instr_done_o
);
  logic [1:0] cnt_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= 2'h0;
      instr_done_o <= 1'b0;
    end else begin
      // gated clock: the core freezes mid-instruction
      if (cpu_clk_enable_i) begin
        cnt_q <= cnt_q + 2'h1;
      end
      instr_done_o <= cpu_clk_enable_i && cnt_q == 2'h3;
    end
  end
endmodule

// file: verif/mcu_interrupt_sequencer_test.sv
// self-checking bench for the interrupt sequencer
`timescale 1ns/1ps

module mcu_interrupt_sequencer_test;
  logic clk_i, rst_i, reg_we_i, reg_re_i, irq_pin_n_i, instr_done_i, re_q;
  logic stop_exec_i, wait_exec_i, mask_set_i, mask_clr_i, mask_o, service_start_o, stack_push_o;
  logic osc_enable_o, cpu_clk_enable_o, timer_clk_enable_o, swi_exec_i;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, te, se;
  logic [4:0] timer_flags_i, serial_flags_i, serial_flag_clear_o, tf, sf;
  logic [15:0] vector_addr_o, v, seed;
  logic [15:0] expq[$];
  int failures = 0;
  int n_compared = 0;
  int hits[4] = '{2, 1, 0, 1};

  mcu_interrupt_sequencer u_mcu_interrupt_sequencer (
    .clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
    .irq_pin_n_i(irq_pin_n_i), .timer_flags_i(timer_flags_i), .serial_flags_i(serial_flags_i),
    .serial_flag_clear_o(serial_flag_clear_o), .instr_done_i(instr_done_i),
    .swi_exec_i(swi_exec_i), .stop_exec_i(stop_exec_i), .wait_exec_i(wait_exec_i),
    .mask_set_i(mask_set_i), .mask_clr_i(mask_clr_i), .mask_o(mask_o),
    .service_start_o(service_start_o), .stack_push_o(stack_push_o),
    .vector_addr_o(vector_addr_o), .osc_enable_o(osc_enable_o),
    .cpu_clk_enable_o(cpu_clk_enable_o), .timer_clk_enable_o(timer_clk_enable_o)
  );

  core_stub u_core_stub (
    .clk_i(clk_i), .rst_i(rst_i), .cpu_clk_enable_i(cpu_clk_enable_o),
    .instr_done_o(instr_done_i)
  );

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [15:0] xs(input logic [15:0] s);
    logic [15:0] t;
    t = s ^ (s << 7);
    t = t ^ (t >> 9);
    return t ^ (t << 8);
  endfunction

  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic take(input string what, input logic [15:0] seen);
    if (expq.size() == 0) check(what, seen, 16'hxxxx);
    else check(what, seen, expq.pop_front());
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_we_i <= 1'b1;
    @(posedge clk_i);
    reg_we_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] d);
    expq.push_back({8'h00, d});
    reg_addr_i <= a;
    reg_re_i <= 1'b1;
    @(posedge clk_i);
    reg_re_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic mset(input logic s);
    if (s) mask_set_i <= 1'b1;
    else mask_clr_i <= 1'b1;
    @(posedge clk_i);
    mask_set_i <= 1'b0;
    mask_clr_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic summarize;
    if (expq.size() != 0) check("missing results", 16'(expq.size()), 16'h0000);
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ************************************************************
  // clock, watcher and watchdog
  // ************************************************************
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    re_q <= reg_re_i;
    if (!rst_i && re_q === 1'b1) take("read data", {8'h00, reg_rdata_o});
    if (!rst_i && service_start_o === 1'b1) take("vector", vector_addr_o);
    if (!rst_i && serial_flag_clear_o !== 5'h00) take("flag clear", {11'h0, serial_flag_clear_o});
  end

  initial begin
    #100000;
    failures++;
    summarize();
  end

  // ************************************************************
  // scenarios
  // ************************************************************
  initial begin
    {rst_i, irq_pin_n_i, re_q} = 3'b110;
    {reg_we_i, reg_re_i, stop_exec_i, wait_exec_i, mask_set_i, mask_clr_i, swi_exec_i} = 7'h00;
    {reg_addr_i, reg_wdata_i, timer_flags_i, serial_flags_i} = 26'h0;
    seed = 16'h318a;
    expq.push_back(irq_seq_pkg::reset_vector);
    step(3);
    rst_i <= 1'b0;
    step(2);
    rd(irq_seq_pkg::misc_control_addr, 8'h90);
    rd(irq_seq_pkg::timer_control_addr, 8'h00);
    rd(irq_seq_pkg::serial_control_two_addr, 8'h00);
    rd(8'h20, 8'h00);
    wr(irq_seq_pkg::misc_control_addr, 8'hb0);
    mset(1'b0);
    wr(irq_seq_pkg::misc_control_addr, 8'hd0);
    rd(irq_seq_pkg::misc_control_addr, 8'hb0);
    $display("reset and protection test done");
    // each option: pin held low, mask opened twice; level mode fires again
    for (int m = 0; m < 4; m++) begin
      mset(1'b1);
      wr(irq_seq_pkg::misc_control_addr, {1'b1, m[1:0], 1'b1, 4'h0});
      irq_pin_n_i <= 1'b0;
      step(8);
      repeat (hits[m]) expq.push_back(irq_seq_pkg::pin_vector);
      repeat (2) begin
        mset(1'b0);
        step(12);
        mset(1'b1);
      end
      irq_pin_n_i <= 1'b1;
      step(8);
    end
    // rising edge left pending by option 11; a new option must drop it
    wr(irq_seq_pkg::misc_control_addr, 8'hb0);
    mset(1'b0);
    step(12);
    mset(1'b1);
    // edge while disabled stays pending until enabled
    wr(irq_seq_pkg::misc_control_addr, 8'ha0);
    irq_pin_n_i <= 1'b0;
    step(8);
    irq_pin_n_i <= 1'b1;
    mset(1'b0);
    step(12);
    mset(1'b1);
    wr(irq_seq_pkg::misc_control_addr, 8'hb0);
    expq.push_back(irq_seq_pkg::pin_vector);
    mset(1'b0);
    step(12);
    mset(1'b1);
    $display("pin test done");
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      {se[7:4], te[7:5], sf, tf} = {seed[15:12], seed[12:10], seed[9:0]};
      {se[3:0], te[4:0]} = 9'h0;
      wr(irq_seq_pkg::timer_control_addr, te);
      wr(irq_seq_pkg::serial_control_two_addr, se);
      timer_flags_i <= tf;
      serial_flags_i <= sf;
      step(2);
      rd(irq_seq_pkg::timer_status_addr, {tf, 3'h0});
      rd(irq_seq_pkg::serial_status_addr, {sf, 3'h0});
      if (sf != 5'h00) expq.push_back({11'h0, sf});
      wr(irq_seq_pkg::serial_data_addr, 8'h00);
      if ((|tf[4:3]) && te[7]) v = irq_seq_pkg::capture_vector;
      else if ((|tf[2:1]) && te[6]) v = irq_seq_pkg::compare_vector;
      else if (tf[0] && te[5]) v = irq_seq_pkg::overflow_vector;
      else if ((sf[4] && se[7]) || (sf[3] && se[6]) || ((|sf[2:1]) && se[5]) || (sf[0] && se[4]))
        v = irq_seq_pkg::serial_vector;
      else v = 16'h0000;
      if (v != 16'h0000) expq.push_back(v);
      mset(1'b0);
      step(12);
      mset(1'b1);
      timer_flags_i <= 5'h00;
      serial_flags_i <= 5'h00;
    end
    $display("timer and serial test done");
    // overflow pending under mask; wait opens the mask and wakes on it
    wr(irq_seq_pkg::timer_control_addr, 8'h20);
    timer_flags_i <= 5'h01;
    step(2);
    expq.push_back(irq_seq_pkg::overflow_vector);
    wait_exec_i <= 1'b1;
    @(posedge clk_i);
    wait_exec_i <= 1'b0;
    step(8);
    mset(1'b1);
    stop_exec_i <= 1'b1;
    @(posedge clk_i);
    stop_exec_i <= 1'b0;
    step(10);
    check("oscillator", {15'h0, osc_enable_o}, 16'h0000);
    expq.push_back(irq_seq_pkg::pin_vector);
    irq_pin_n_i <= 1'b0;
    step(10);
    irq_pin_n_i <= 1'b1;
    mset(1'b1);
    timer_flags_i <= 5'h00;
    step(8);
    // por flag drops on a zero write; option bits kept as written
    wr(irq_seq_pkg::misc_control_addr, 8'h30);
    rd(irq_seq_pkg::misc_control_addr, 8'h30);
    // swi is served at an instruction end even while masked
    expq.push_back(irq_seq_pkg::swi_vector);
    swi_exec_i <= 1'b1;
    @(posedge clk_i iff instr_done_i === 1'b1);
    swi_exec_i <= 1'b0;
    step(4);
    $display("wait and stop test done");
    summarize();
  end
endmodule
